// ===== hw/dplc_pkg.sv
package dplc_pkg;

   // register byte offsets
   localparam logic [7:0] DPLC_OFF_CMD     = 8'h00;
   localparam logic [7:0] DPLC_OFF_DATA    = 8'h04;
   localparam logic [7:0] DPLC_OFF_STATUS  = 8'h08;
   localparam logic [7:0] DPLC_OFF_ERROR   = 8'h0C;
   localparam logic [7:0] DPLC_OFF_SEC     = 8'h10;
   localparam logic [7:0] DPLC_OFF_IDENT92 = 8'h14;
   localparam logic [7:0] DPLC_OFF_RESET   = 8'h18;

   // command codes
   localparam logic [7:0] DPLC_OP_SET_PW   = 8'hF1;
   localparam logic [7:0] DPLC_OP_UNLOCK   = 8'hF2;
   localparam logic [7:0] DPLC_OP_FREEZE   = 8'hF5;

   // parameter sector layout, in 16-bit words
   localparam logic [7:0] DPLC_WORD_LAST   = 8'hFF;
   localparam int         DPLC_PW_WORDS    = 16;
   localparam logic [7:0] DPLC_PW_FIRST    = 8'h01;
   localparam logic [7:0] DPLC_PW_LAST     = 8'h10;
   localparam logic [7:0] DPLC_REV_WORD    = 8'h11;
   localparam int         DPLC_CTL_ID_BIT  = 0;
   localparam int         DPLC_CTL_LVL_BIT = 8;
   localparam logic [15:0] DPLC_REV_KEEP_LO = 16'h0000;
   localparam logic [15:0] DPLC_REV_KEEP_HI = 16'hFFFF;

   // status and error bit positions
   localparam int DPLC_ST_BSY  = 7;
   localparam int DPLC_ST_RDY  = 6;
   localparam int DPLC_ST_DRQ  = 3;
   localparam int DPLC_ST_ERR  = 0;
   localparam int DPLC_ER_ABT  = 2;

   // security state readback bit positions
   localparam int DPLC_SEC_EN      = 0;
   localparam int DPLC_SEC_LOCKED  = 1;
   localparam int DPLC_SEC_MAX     = 2;
   localparam int DPLC_SEC_FROZEN  = 3;
   localparam int DPLC_SEC_EXPIRED = 4;
   localparam int DPLC_SEC_CNT_LO  = 8;

   // reset control bit positions
   localparam int DPLC_RST_HARD = 0;
   localparam int DPLC_RST_POR  = 1;

   // reset values
   localparam logic [2:0]  DPLC_ATTEMPTS_INIT = 3'h5;
   localparam logic [15:0] DPLC_MASTER_PW_INIT = 16'h0000;
   localparam logic [15:0] DPLC_REV_INIT       = 16'h0000;

   typedef enum logic [1:0] {
      DPLC_IDLE,
      DPLC_XFER,
      DPLC_EXEC
   } dplc_state_t;

endpackage

// ===== hw/dplc_top.sv
`timescale 1ns/1ps
// What this block does
// - set-password command stores user or master password and may enable locking.
// - user password set leaves device unlocked until the next power-on or hard reset.
// - master password set only records it; never causes locking later.
// - each password command takes exactly one 256-word sector, then acts on it.
// - word 0 bit 0 picks user/master, bit 8 picks high/maximum level.
// - password is words 1 to 16; all 32 bytes stored and compared.
// - word 17 revision code updates unless 0000h or FFFFh; master only.
// - stored master revision code is readable as identification word 92.
// - user at high level: lock from power-on; user or master password unlocks.
// - user at maximum level: only the user password unlocks.
// - master selected at either level never enables the lock feature.
// - matching unlock unlocks; later power-on or hard reset relocks if enabled.
// - unlock sector: word 0 bit 0 identifier, words 1 to 16 password.
// - master unlock compared at high level, refused at maximum level.
// - user unlock compared against stored user password.
// - mismatch aborts and decrements failed-attempt counter starting at five.
// - counter at zero rejects password commands until power-on reset, hard reset or power off.
// - lock feature off and user unlock named: abort.
// - frozen device rejects set-password and unlock; only power off unfreezes.
module dplc_top (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   import dplc_pkg::*;

   dplc_state_t state_reg;
   logic [7:0]  cmd_reg;
   logic [7:0]  widx_reg;
   logic [15:0] ctl_reg;
   logic [15:0] rev_word_reg;
   logic [15:0] param_pw [DPLC_PW_WORDS];
   logic [15:0] user_pw  [DPLC_PW_WORDS];
   logic [15:0] master_pw[DPLC_PW_WORDS];
   logic [15:0] rev_code_reg;
   logic        lock_en_reg;
   logic        locked_reg;
   logic        level_max_reg;
   logic        frozen_reg;
   logic [2:0]  attempts_reg;
   logic        abt_reg;
   logic        err_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;

   logic        setup_w;
   logic        wr_done;
   logic        addr_ok;
   logic        cmd_wr;
   logic        data_wr;
   logic        hard_rst;
   logic        por_rst;
   logic        any_rst;
   logic        expired;
   logic        id_master;
   logic        exec_set;
   logic        exec_unl;
   logic        unl_refuse;
   logic        unl_miss;
   logic        unl_ok;
   logic        pw_match;
   logic        cmd_pw;
   logic        cmd_reject;
   logic        rev_update;
   logic [31:0] rd_mux;

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // apb decode
   assign setup_w = psel & ~penable;
   assign wr_done = psel & penable & pready_reg & pwrite & ~pslverr_reg;
   always_comb begin
      case (paddr)
         DPLC_OFF_CMD, DPLC_OFF_DATA, DPLC_OFF_STATUS, DPLC_OFF_ERROR,
         DPLC_OFF_SEC, DPLC_OFF_IDENT92, DPLC_OFF_RESET: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign cmd_wr   = wr_done & (paddr == DPLC_OFF_CMD) & (state_reg == DPLC_IDLE);
   assign data_wr  = wr_done & (paddr == DPLC_OFF_DATA) & (state_reg == DPLC_XFER);
   assign hard_rst = wr_done & (paddr == DPLC_OFF_RESET) & pwdata[DPLC_RST_HARD];
   assign por_rst  = wr_done & (paddr == DPLC_OFF_RESET) & pwdata[DPLC_RST_POR];
   assign any_rst  = hard_rst | por_rst;
   assign expired  = (attempts_reg == 3'h0);

   // password commands refused before any data moves
   assign cmd_pw     = (pwdata[7:0] == DPLC_OP_SET_PW) | (pwdata[7:0] == DPLC_OP_UNLOCK);
   assign cmd_reject = cmd_pw & (frozen_reg | expired);

   assign id_master  = ctl_reg[DPLC_CTL_ID_BIT];
   assign exec_set   = (state_reg == DPLC_EXEC) & (cmd_reg == DPLC_OP_SET_PW) & ~any_rst;
   assign exec_unl   = (state_reg == DPLC_EXEC) & (cmd_reg == DPLC_OP_UNLOCK) & ~any_rst;

   // full 32-byte compare against the selected stored password
   always_comb begin
      pw_match = 1'b1;
      for (int i = 0; i < DPLC_PW_WORDS; i++) begin
         if (id_master) begin
            if (param_pw[i] != master_pw[i]) pw_match = 1'b0;
         end else begin
            if (param_pw[i] != user_pw[i]) pw_match = 1'b0;
         end
      end
   end

   assign unl_refuse = exec_unl & ((id_master & level_max_reg) | (~id_master & ~lock_en_reg));
   assign unl_miss   = exec_unl & ~unl_refuse & ~pw_match;
   assign unl_ok     = exec_unl & ~unl_refuse & pw_match;
   assign rev_update = exec_set & id_master &
                       (rev_word_reg != DPLC_REV_KEEP_LO) & (rev_word_reg != DPLC_REV_KEEP_HI);

   // command sequencer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= DPLC_IDLE;
         cmd_reg   <= 8'h00;
      end else if (any_rst) begin
         state_reg <= DPLC_IDLE;
      end else begin
         case (state_reg)
            DPLC_IDLE: begin
               if (cmd_wr) begin
                  cmd_reg <= pwdata[7:0];
                  if (cmd_pw && !cmd_reject) begin
                     state_reg <= DPLC_XFER;
                  end
               end
            end
            DPLC_XFER: begin
               if (data_wr && widx_reg == DPLC_WORD_LAST) begin
                  state_reg <= DPLC_EXEC;
               end
            end
            DPLC_EXEC: state_reg <= DPLC_IDLE;
            default:   state_reg <= DPLC_IDLE;
         endcase
      end
   end

   // sector word capture; reserved words dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         widx_reg     <= 8'h00;
         ctl_reg      <= 16'h0000;
         rev_word_reg <= 16'h0000;
         for (int i = 0; i < DPLC_PW_WORDS; i++) begin
            param_pw[i] <= 16'h0000;
         end
      end else if (cmd_wr) begin
         widx_reg <= 8'h00;
      end else if (data_wr) begin
         widx_reg <= widx_reg + 8'h01;
         if (widx_reg == 8'h00) begin
            ctl_reg <= pwdata[15:0];
         end
         if (widx_reg >= DPLC_PW_FIRST && widx_reg <= DPLC_PW_LAST) begin
            param_pw[4'(widx_reg - DPLC_PW_FIRST)] <= pwdata[15:0];
         end
         if (widx_reg == DPLC_REV_WORD) begin
            rev_word_reg <= pwdata[15:0];
         end
      end
   end

   // stored passwords and revision code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rev_code_reg <= DPLC_REV_INIT;
         for (int i = 0; i < DPLC_PW_WORDS; i++) begin
            user_pw[i]   <= 16'h0000;
            master_pw[i] <= DPLC_MASTER_PW_INIT;
         end
      end else if (exec_set) begin
         for (int i = 0; i < DPLC_PW_WORDS; i++) begin
            if (id_master) begin
               master_pw[i] <= param_pw[i];
            end else begin
               user_pw[i] <= param_pw[i];
            end
         end
         if (rev_update) begin
            rev_code_reg <= rev_word_reg;
         end
      end
   end

   // lock feature and lock state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_en_reg   <= 1'b0;
         locked_reg    <= 1'b0;
         level_max_reg <= 1'b0;
      end else if (any_rst) begin
         locked_reg <= lock_en_reg;
      end else if (exec_set && !id_master) begin
         lock_en_reg   <= 1'b1;
         level_max_reg <= ctl_reg[DPLC_CTL_LVL_BIT];
      end else if (unl_ok) begin
         locked_reg <= 1'b0;
      end
   end

   // frozen mode, left only by power off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frozen_reg <= 1'b0;
      end else if (cmd_wr && pwdata[7:0] == DPLC_OP_FREEZE && !expired) begin
         frozen_reg <= 1'b1;
      end
   end

   // failed-attempt counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         attempts_reg <= DPLC_ATTEMPTS_INIT;
      end else if (any_rst) begin
         attempts_reg <= DPLC_ATTEMPTS_INIT;
      end else if (unl_miss) begin
         attempts_reg <= attempts_reg - 3'h1;
      end
   end

   // command completion flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abt_reg <= 1'b0;
         err_reg <= 1'b0;
      end else if (any_rst) begin
         abt_reg <= 1'b0;
         err_reg <= 1'b0;
      end else if (cmd_wr) begin
         abt_reg <= 1'b0;
         err_reg <= 1'b0;
         if (cmd_reject || (!cmd_pw && pwdata[7:0] != DPLC_OP_FREEZE)
             || (pwdata[7:0] == DPLC_OP_FREEZE && expired)) begin
            abt_reg <= 1'b1;
            err_reg <= 1'b1;
         end
      end else if (unl_refuse || unl_miss) begin
         abt_reg <= 1'b1;
         err_reg <= 1'b1;
      end
   end

   // read mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         DPLC_OFF_STATUS: begin
            rd_mux[DPLC_ST_BSY] = (state_reg == DPLC_EXEC);
            rd_mux[DPLC_ST_RDY] = 1'b1;
            rd_mux[DPLC_ST_DRQ] = (state_reg == DPLC_XFER);
            rd_mux[DPLC_ST_ERR] = err_reg;
         end
         DPLC_OFF_ERROR:   rd_mux[DPLC_ER_ABT] = abt_reg;
         DPLC_OFF_SEC: begin
            rd_mux[DPLC_SEC_EN]      = lock_en_reg;
            rd_mux[DPLC_SEC_LOCKED]  = locked_reg;
            rd_mux[DPLC_SEC_MAX]     = level_max_reg;
            rd_mux[DPLC_SEC_FROZEN]  = frozen_reg;
            rd_mux[DPLC_SEC_EXPIRED] = expired;
            rd_mux[DPLC_SEC_CNT_LO +: 3] = attempts_reg;
         end
         DPLC_OFF_IDENT92: rd_mux[15:0] = rev_code_reg;
         default:          rd_mux = 32'h0000_0000;
      endcase
   end

   // apb response, one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= setup_w;
         pslverr_reg <= setup_w & ~addr_ok;
         prdata_reg  <= (setup_w && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence abort_shown_s;
      abt_reg && err_reg && state_reg == DPLC_IDLE;
   endsequence

   sequence counter_dropped_s;
      attempts_reg == $past(attempts_reg) - 3'h1;
   endsequence

   sequence result_clean_s;
      !abt_reg && !err_reg && state_reg == DPLC_IDLE;
   endsequence

   set_no_lock_a: assert property (exec_set |=> locked_reg == $past(locked_reg))
      else $error("set password changed lock state at once");
   master_no_enable_a: assert property (exec_set && id_master |=> lock_en_reg == $past(lock_en_reg))
      else $error("master password set changed lock enable");
   user_enable_a: assert property (exec_set && !id_master
                                   |=> lock_en_reg && level_max_reg == $past(ctl_reg[DPLC_CTL_LVL_BIT]))
      else $error("user password set did not enable lock with level");
   rev_keep_a: assert property (exec_set && id_master
                                && (rev_word_reg == DPLC_REV_KEEP_LO || rev_word_reg == DPLC_REV_KEEP_HI)
                                |=> $stable(rev_code_reg))
      else $error("reserved revision code value changed stored code");
   mismatch_count_a: assert property (unl_miss |=> counter_dropped_s and abort_shown_s)
      else $error("mismatch did not abort and decrement");
   expired_reject_a: assert property (cmd_wr && cmd_pw && expired |=> abort_shown_s ##1 state_reg == DPLC_IDLE)
      else $error("command accepted with attempts exhausted");
   frozen_reject_a: assert property (cmd_wr && cmd_pw && frozen_reg |=> abort_shown_s)
      else $error("password command accepted while frozen");
   reset_relock_a: assert property (por_rst |=> locked_reg == $past(lock_en_reg)
                                    && attempts_reg == DPLC_ATTEMPTS_INIT)
      else $error("reset did not relock or reload counter");
   max_master_a: assert property (exec_unl && id_master && level_max_reg
                                  |=> abort_shown_s and $stable(locked_reg) and $stable(attempts_reg))
      else $error("master unlock at maximum level not refused");
   unlock_ok_a: assert property (unl_ok |=> !locked_reg && !abt_reg)
      else $error("matching unlock did not unlock");
   frozen_sticky_a: assert property (frozen_reg |=> frozen_reg)
      else $error("frozen state left without power off");
   sector_len_a: assert property (state_reg == DPLC_XFER && data_wr && widx_reg != DPLC_WORD_LAST
                                  |=> state_reg == DPLC_XFER)
      else $error("sector ended before its last word");
   user_off_abort_a: assert property (exec_unl && !id_master && !lock_en_reg
                                      |=> abort_shown_s and $stable(attempts_reg))
      else $error("user unlock with lock disabled not aborted");
   rev_update_a: assert property (rev_update |=> rev_code_reg == $past(rev_word_reg))
      else $error("valid revision code not stored");
   ident_read_a: assert property (setup_w && !pwrite && paddr == DPLC_OFF_IDENT92
                                  |=> prdata == {16'h0000, $past(rev_code_reg)})
      else $error("identification word 92 does not show revision code");
   user_store_a: assert property (exec_set && !id_master
                                  |=> user_pw[0] == $past(param_pw[0]) && user_pw[15] == $past(param_pw[15]))
      else $error("user password not stored in full");
   master_store_a: assert property (exec_set && id_master
                                    |=> master_pw[15] == $past(param_pw[15]) && $stable(user_pw[15]))
      else $error("master password set touched the wrong store");
   soft_reset_a: assert property (any_rst
                                  |=> result_clean_s and locked_reg == $past(lock_en_reg)
                                      and attempts_reg == DPLC_ATTEMPTS_INIT)
      else $error("soft reset did not clear flags, relock and reload counter");
   cmd_accept_a: assert property (cmd_wr && cmd_pw && !cmd_reject
                                  |=> state_reg == DPLC_XFER && widx_reg == 8'h00 && !abt_reg && !err_reg)
      else $error("password command did not open a clean sector transfer");
   bad_opcode_a: assert property (cmd_wr && !cmd_pw && pwdata[7:0] != DPLC_OP_FREEZE
                                  |=> abort_shown_s)
      else $error("unknown opcode not aborted");
   master_high_a: assert property (exec_unl && id_master && !level_max_reg && pw_match
                                   |=> !locked_reg && !abt_reg)
      else $error("master password refused at high level");
   drq_shown_a: assert property (setup_w && !pwrite && paddr == DPLC_OFF_STATUS && state_reg == DPLC_XFER
                                 |=> prdata[DPLC_ST_DRQ])
      else $error("sector wait not flagged in status");

endmodule // dplc_top

// ===== verif/dplc_host.sv
`timescale 1ns/1ps
module dplc_host (
   // apb master side
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata,
   // apb answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   import dplc_pkg::*;
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end
   // request held until pready seen high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // command then one whole sector; bad flips bit 0 of the last password word
   task automatic cmd_sector(input logic [7:0] op, input logic [15:0] w0, input logic [7:0] seed,
                             input logic bad, input logic [15:0] rev);
      logic [31:0] r;
      logic        e;
      logic [15:0] w;
      xfer(1'b1, DPLC_OFF_CMD, {24'h000000, op}, r, e);
      for (int i = 0; i < 256; i++) begin
         if (i == 0)
            w = w0;
         else if (i <= DPLC_PW_WORDS)
            w = {seed, 8'(i)} ^ {15'h0000, bad && (i == DPLC_PW_WORDS)};
         else if (i == 17)
            w = rev;
         else
            w = 16'hA5A5;
         xfer(1'b1, DPLC_OFF_DATA, {16'h0000, w}, r, e);
      end
   endtask
endmodule // dplc_host

// ===== verif/drive_password_lock_commands_bench.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin checked++; if ((g) !== (x)) begin num_errors++; \
   $display("[FAIL] %0s exp %h got %h", n, x, g); end end
module drive_password_lock_commands_bench;
   import dplc_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] r;
   logic        e;
   int          num_errors = 0;
   int          checked = 0;
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   dplc_top i_dplc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   dplc_host i_dplc_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // security readback: f = expired, frozen, max, locked, enabled
   function automatic logic [31:0] sec(input logic [4:0] f, input logic [2:0] n);
      return {21'h000000, n, 3'h0, f};
   endfunction
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
      i_dplc_host.xfer(1'b0, a, 32'h0000_0000, r, e);
      `CHK($sformatf("reg %h", a), x, r & m)
      `CHK("pslverr", 1'b0, e)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_dplc_host.xfer(1'b1, a, d, r, e);
      `CHK("pslverr", 1'b0, e)
   endtask
   task automatic note(input string s);
      $display("test %0s done", s);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      test_done();
   end
   initial begin
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(DPLC_OFF_SEC, sec(5'h00, 3'h5));
      rd(DPLC_OFF_STATUS, 32'h0000_0040);
      i_dplc_host.xfer(1'b0, 8'h1C, 32'h0000_0000, r, e);
      `CHK("unmapped pslverr", 1'b1, e)
      note("reset");
      i_dplc_host.cmd_sector(DPLC_OP_SET_PW, 16'h00FF, 8'hA0, 1'b0, 16'h1234);
      rd(DPLC_OFF_STATUS, 32'h0000_0040);
      rd(DPLC_OFF_IDENT92, 32'h0000_1234);
      i_dplc_host.cmd_sector(DPLC_OP_SET_PW, 16'h01FF, 8'hA0, 1'b0, 16'hFFFF);
      rd(DPLC_OFF_IDENT92, 32'h0000_1234);
      i_dplc_host.cmd_sector(DPLC_OP_SET_PW, 16'h0001, 8'hA0, 1'b0, 16'h0000);
      rd(DPLC_OFF_IDENT92, 32'h0000_1234);
      wr(DPLC_OFF_RESET, 32'h0000_0002);
      rd(DPLC_OFF_SEC, sec(5'h00, 3'h5));
      note("master");
      i_dplc_host.cmd_sector(DPLC_OP_UNLOCK, 16'hFFFE, 8'hB0, 1'b0, 16'h0000);
      rd(DPLC_OFF_ERROR, 32'h0000_0004);
      rd(DPLC_OFF_STATUS, 32'h0000_0041);
      wr(DPLC_OFF_RESET, 32'h0000_0001);
      rd(DPLC_OFF_ERROR, 32'h0000_0000);
      rd(DPLC_OFF_SEC, sec(5'h00, 3'h5));
      note("disabled");
      i_dplc_host.cmd_sector(DPLC_OP_SET_PW, 16'h0E0E, 8'hB0, 1'b0, 16'h7777);
      rd(DPLC_OFF_SEC, sec(5'h01, 3'h5));
      rd(DPLC_OFF_IDENT92, 32'h0000_1234);
      wr(DPLC_OFF_RESET, 32'h0000_0002);
      rd(DPLC_OFF_SEC, sec(5'h03, 3'h5));
      i_dplc_host.cmd_sector(DPLC_OP_UNLOCK, 16'h0001, 8'hA0, 1'b0, 16'h0000);
      rd(DPLC_OFF_SEC, sec(5'h01, 3'h5));
      wr(DPLC_OFF_RESET, 32'h0000_0001);
      rd(DPLC_OFF_SEC, sec(5'h03, 3'h5));
      i_dplc_host.cmd_sector(DPLC_OP_UNLOCK, 16'hFFFE, 8'hB0, 1'b1, 16'h0000);
      rd(DPLC_OFF_ERROR, 32'h0000_0004);
      rd(DPLC_OFF_SEC, sec(5'h03, 3'h4));
      i_dplc_host.cmd_sector(DPLC_OP_UNLOCK, 16'hFFFE, 8'hB0, 1'b0, 16'h0000);
      rd(DPLC_OFF_SEC, sec(5'h01, 3'h4));
      rd(DPLC_OFF_ERROR, 32'h0000_0000);
      note("high level");
      i_dplc_host.cmd_sector(DPLC_OP_SET_PW, 16'h0100, 8'hB0, 1'b0, 16'h0000);
      wr(DPLC_OFF_RESET, 32'h0000_0002);
      rd(DPLC_OFF_SEC, sec(5'h07, 3'h5));
      i_dplc_host.cmd_sector(DPLC_OP_UNLOCK, 16'h0001, 8'hA0, 1'b0, 16'h0000);
      rd(DPLC_OFF_ERROR, 32'h0000_0004);
      rd(DPLC_OFF_SEC, sec(5'h07, 3'h5));
      note("maximum level");
      wr(DPLC_OFF_RESET, 32'h0000_0001);
      for (int k = 0; k < 5; k++) begin
         i_dplc_host.cmd_sector(DPLC_OP_UNLOCK, 16'hFFFE, 8'hC0, 1'b0, 16'h0000);
         rd(DPLC_OFF_ERROR, 32'h0000_0004);
         rd(DPLC_OFF_SEC, sec((k == 4) ? 5'h17 : 5'h07, 3'(4 - k)));
      end
      wr(DPLC_OFF_CMD, {24'h000000, DPLC_OP_UNLOCK});
      rd(DPLC_OFF_STATUS, 32'h0000_0041);
      wr(DPLC_OFF_RESET, 32'h0000_0001);
      rd(DPLC_OFF_SEC, sec(5'h07, 3'h5));
      note("attempts");
      wr(DPLC_OFF_CMD, {24'h000000, DPLC_OP_SET_PW});
      rd(DPLC_OFF_STATUS, 32'h0000_0048);
      wr(DPLC_OFF_RESET, 32'h0000_0001);
      rd(DPLC_OFF_STATUS, 32'h0000_0040);
      wr(DPLC_OFF_CMD, 32'h0000_0000);
      rd(DPLC_OFF_STATUS, 32'h0000_0041);
      note("cancel and opcode");
      wr(DPLC_OFF_CMD, {24'h000000, DPLC_OP_FREEZE});
      rd(DPLC_OFF_SEC, sec(5'h0F, 3'h5));
      wr(DPLC_OFF_CMD, {24'h000000, DPLC_OP_SET_PW});
      rd(DPLC_OFF_STATUS, 32'h0000_0041);
      wr(DPLC_OFF_RESET, 32'h0000_0001);
      rd(DPLC_OFF_SEC, sec(5'h0F, 3'h5));
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(DPLC_OFF_SEC, sec(5'h00, 3'h5));
      note("frozen");
      test_done();
   end
endmodule // drive_password_lock_commands_bench
